// >>> sheet_controller.sv
// Controller end: runs measurement and zero-adjust handshakes on APB orders.
// Assumes APB master on clk; detector lines arrive from a foreign domain.
//
// The placing of the registers and register access over APB were left to the implementer.
`timescale 1ns/10ps
module sheet_controller
    import sheet_pkg::*;
#(
    parameter int MS_DIV = CYCLES_PER_MS
) (
    input wire logic clk,
    input wire logic srst,
    sheet_link_if.plc link,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr
);
    generate
        if (MS_DIV < 2) begin : g_bad
            $error("sheet_controller: MS_DIV too small");
        end
    endgenerate

    typedef enum logic [2:0] {
        H_IDLE,
        H_QUIET,
        H_RAISE,
        H_WAIT,
        H_RUN,
        H_REST
    } hstate_t;

    // --------------------
    // Synchronisers for ready and result lines
    // --------------------
    logic [3:0] pin_in;
    logic [3:0] s1_q;
    logic [3:0] s2_q;
    logic [3:0] s3_q;
    logic [3:0] lvl_q;
    assign pin_in = {link.sheet_result_outs, link.ready_out};

    generate
        for (genvar g = 0; g < 4; g++) begin : g_sync
            always_ff @(posedge clk) begin
                if (srst) begin
                    s1_q[g] <= 1'b0;
                    s2_q[g] <= 1'b0;
                    s3_q[g] <= 1'b0;
                    lvl_q[g] <= 1'b0;
                end else begin
                    s1_q[g] <= pin_in[g];
                    s2_q[g] <= s1_q[g];
                    s3_q[g] <= s2_q[g];
                    lvl_q[g] <= (s2_q[g] == s3_q[g]) ? s3_q[g] : lvl_q[g];
                end
            end
        end
    endgenerate

    // --------------------
    // APB slave, one wait state
    // --------------------
    logic [2:0] cfg_q;
    logic [2:0] cfg_d;
    logic pready_q;
    logic [31:0] prdata_q;
    logic [31:0] prdata_d;
    logic pslverr_q;
    logic pslverr_d;
    logic wr_cmd;
    logic [2:0] res;
    logic hit;
    hstate_t state_q;
    logic fault_q;
    logic done_q;
    logic [2:0] result_q;

    assign res = lvl_q[3:1] ^ {3{cfg_q[CFG_INV]}};
    assign hit = (paddr == REG_CMD) || (paddr == REG_CFG) || (paddr == REG_STATUS);
    // Writes take effect at the edge where pready is seen high
    assign wr_cmd = psel & penable & pready_q & pwrite & (paddr == REG_CMD);

    always_comb begin
        cfg_d = cfg_q;
        prdata_d = prdata_q;
        pslverr_d = 1'b0;
        if (psel && penable && !pready_q) begin
            pslverr_d = ~hit;
            prdata_d = 32'h0;
            if (!pwrite && paddr == REG_CFG) begin
                prdata_d[2:0] = cfg_q;
            end else if (!pwrite && paddr == REG_STATUS) begin
                prdata_d[ST_BUSY] = (state_q != H_IDLE);
                prdata_d[ST_FAULT] = fault_q;
                prdata_d[ST_DONE] = done_q;
                prdata_d[ST_READY] = lvl_q[0];
                prdata_d[ST_RES_LSB +: 3] = result_q;
            end
        end
        if (psel && penable && pready_q && pwrite && paddr == REG_CFG) begin
            cfg_d = pwdata[2:0];
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            cfg_q <= CFG_RESET;
            pready_q <= 1'b0;
            prdata_q <= 32'h0;
            pslverr_q <= 1'b0;
        end else begin
            cfg_q <= cfg_d;
            pready_q <= psel & penable & ~pready_q;
            prdata_q <= prdata_d;
            pslverr_q <= pslverr_d;
        end
    end

    // --------------------
    // Millisecond prescaler
    // --------------------
    logic [31:0] div_q;
    logic tick_q;
    always_ff @(posedge clk) begin
        if (srst) begin
            div_q <= 32'h0;
            tick_q <= 1'b0;
        end else begin
            div_q <= (div_q == 32'(MS_DIV - 1)) ? 32'h0 : div_q + 32'h1;
            tick_q <= (div_q == 32'(MS_DIV - 1));
        end
    end

    // --------------------
    // Handshake sequencer
    // --------------------
    hstate_t state_d;
    logic [4:0] guard_q;
    logic [4:0] guard_d;
    logic zero_job_q;
    logic zero_job_d;
    logic [15:0] ms_q;
    logic [15:0] ms_d;
    logic [16:0] rest_q;
    logic [16:0] rest_d;
    logic start_q;
    logic start_d;
    logic zero_q;
    logic zero_d;
    logic fault_d;
    logic done_d;
    logic [2:0] result_d;
    logic acked;

    // Zero adjust acks high, measurement acks low
    assign acked = zero_job_q ? (res == RES_ALL) : (res == RES_NONE);

    always_comb begin
        state_d = state_q;
        zero_job_d = zero_job_q;
        ms_d = (tick_q && ms_q != 16'hFFFF) ? ms_q + 16'h1 : ms_q;
        rest_d = (tick_q && rest_q != 17'h0) ? rest_q - 17'h1 : rest_q;
        start_d = start_q;
        zero_d = zero_q;
        fault_d = fault_q;
        done_d = done_q;
        result_d = result_q;
        // Stale lines look like an ack until the round trip has passed
        guard_d = (state_q == H_RAISE && guard_q != ACK_GUARD_CY) ? guard_q + 5'h1 : guard_q;
        if (state_q != H_RAISE) begin
            guard_d = 5'h0;
        end
        case (state_q)
            H_IDLE: begin
                start_d = 1'b0;
                zero_d = 1'b0;
                if (wr_cmd && (pwdata[CMD_MEAS] || pwdata[CMD_ZERO])) begin
                    state_d = H_QUIET;
                    zero_job_d = ~pwdata[CMD_MEAS];
                    ms_d = 16'h0;
                    fault_d = 1'b0;
                    done_d = 1'b0;
                end
            end
            H_QUIET: begin
                // Rest debt from the previous run is paid here too
                if (ms_q > QUIET_MS && rest_q == 17'h0) begin // RL4 RL14 RL2
                    ms_d = 16'h0;
                    if (!lvl_q[0]) begin
                        state_d = H_IDLE; // RL3
                        fault_d = 1'b1;
                    end else begin
                        state_d = H_RAISE;
                        start_d = ~zero_job_q;
                        zero_d = zero_job_q;
                    end
                end
            end
            H_RAISE: begin
                // Slow scan never trusts the ack and just waits it out
                if ((!cfg_q[CFG_SLOW] && acked && guard_q == ACK_GUARD_CY) || ms_q > ACK_MS) begin // RL6 RL8 RL16
                    zero_d = 1'b0;
                    if (!zero_job_q && cfg_q[CFG_CONT]) begin
                        state_d = H_RUN;
                    end else begin
                        state_d = H_WAIT;
                        start_d = 1'b0;
                    end
                end
            end
            H_WAIT: begin
                if (zero_job_q ? (res == RES_NONE) : (res != RES_NONE && res != RES_ALL)) begin
                    result_d = res;
                    done_d = 1'b1;
                    state_d = H_REST;
                    rest_d = zero_job_q ? 17'h0 : {ms_q, 1'b0}; // RL2
                end
            end
            H_RUN: begin
                if (res != RES_NONE) begin
                    result_d = res;
                end
                // Burst is cut off to keep the sensor from drifting warm
                if ((wr_cmd && pwdata[CMD_STOP]) || ms_q >= RUN_LIMIT_MS) begin // RL2
                    start_d = 1'b0;
                    done_d = 1'b1;
                    state_d = H_REST;
                    rest_d = {ms_q, 1'b0};
                end
            end
            H_REST: begin
                state_d = H_IDLE;
            end
            default: begin
                state_d = H_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            state_q <= H_IDLE;
            zero_job_q <= 1'b0;
            ms_q <= 16'h0;
            rest_q <= 17'h0;
            start_q <= 1'b0;
            zero_q <= 1'b0;
            fault_q <= 1'b0;
            done_q <= 1'b0;
            result_q <= 3'h0;
            guard_q <= 5'h0;
        end else begin
            guard_q <= guard_d;
            state_q <= state_d;
            zero_job_q <= zero_job_d;
            ms_q <= ms_d;
            rest_q <= rest_d;
            start_q <= start_d;
            zero_q <= zero_d;
            fault_q <= fault_d;
            done_q <= done_d;
            result_q <= result_d;
        end
    end

    assign link.measure_start_in = start_q;
    assign link.zero_adjust_in = zero_q;
    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
endmodule

// >>> sheet_pkg.sv
// Shared constants for the sheet measurement handshake: timing, layout, registers.
// Assumes both ends run on one 200 MHz clock with a synchronous reset.
package sheet_pkg;
    // --------------------
    // Clock and time base
    // --------------------
    localparam int CLK_HZ = 200_000_000;
    localparam int CYCLES_PER_MS = CLK_HZ / 1000;
    // --------------------
    // Handshake times in milliseconds, ack guard in clock cycles, default sensor count
    // --------------------
    localparam logic [15:0] QUIET_MS = 16'd30;
    localparam logic [15:0] ACK_MS = 16'd30;
    localparam logic [4:0] ACK_GUARD_CY = 5'h10;
    localparam logic [15:0] SLOW_SCAN_MS = 16'd20;
    localparam logic [15:0] RUN_LIMIT_MS = 16'd10000;
    localparam logic [15:0] ZERO_ADJ_MS = 16'd7000;
    localparam logic [15:0] PAUSE_SHORT_MS = 16'd500;
    localparam logic [15:0] PAUSE_MID_MS = 16'd1000;
    localparam logic [15:0] PAUSE_LONG_MS = 16'd2000;
    localparam int REACTION_MS_DEF = 50;
    localparam int NUM_SENSORS_DEF = 4;
    // --------------------
    // Result line layout (one-hot)
    // --------------------
    localparam int RES_ZERO = 0;
    localparam int RES_ONE = 1;
    localparam int RES_TWO = 2;
    localparam logic [2:0] RES_NONE = 3'h0;
    localparam logic [2:0] RES_ALL = 3'h7;
    // --------------------
    // Controller registers (APB byte addresses, fields)
    // --------------------
    localparam logic [7:0] REG_CMD = 8'h00;
    localparam logic [7:0] REG_CFG = 8'h04;
    localparam logic [7:0] REG_STATUS = 8'h08;
    localparam int CMD_MEAS = 0;
    localparam int CMD_ZERO = 1;
    localparam int CMD_STOP = 2;
    localparam int CFG_CONT = 0;
    localparam int CFG_SLOW = 1;
    localparam int CFG_INV = 2;
    localparam logic [2:0] CFG_RESET = 3'h0;
    localparam int ST_BUSY = 0;
    localparam int ST_FAULT = 1;
    localparam int ST_DONE = 2;
    localparam int ST_READY = 3;
    localparam int ST_RES_LSB = 4;
endpackage

// >>> sheet_link_if.sv
// Discrete handshake wires between the controller and the detector.
// Assumes both ends share clk; the testbench instantiates and joins them.
`timescale 1ns/10ps
interface sheet_link_if;
    logic measure_start_in;
    logic zero_adjust_in;
    logic ready_out;
    logic [2:0] sheet_result_outs;

    // Detector end
    modport dev (
        input measure_start_in,
        input zero_adjust_in,
        output ready_out,
        output sheet_result_outs
    );

    // Controller end
    modport plc (
        output measure_start_in,
        output zero_adjust_in,
        input ready_out,
        input sheet_result_outs
    );
endinterface

// >>> sheet_detector.sv
// Detector end of the handshake: start/stop measurement, continuous mode, zero adjust.
// Assumes handshake inputs come from a foreign domain; sensor results are local logic.
`timescale 1ns/10ps

// Operation
// RL1: Single result held until next action
// RL2: Controller limits runs, rests twice as long
// RL3: Controller checks ready before any sequence
// RL4: Controller keeps inputs low 30 ms first
// RL5: Results low within 30 ms of start
// RL6: Controller drops start on ack or 30 ms
// RL7: Result shown after reaction delay
// RL8: Slow controller skips ack, polls result
// RL9: Continuous mode repeats while start high
// RL10: Start low aborts, last result held
// RL11: Pause by sensor type between repeats
// RL12: Sequencer mode drives combined summary
// RL13: Zero adjust ignored unless enabled
// RL14: Controller keeps inputs low before zero
// RL15: Results high within 30 ms of zero
// RL16: Controller drops zero on ack or 30 ms
// RL17: Zero adjust done in 7 s, outputs low
// RL18: Ready low on keypad, fault, test
// RL19: Zero-volt level inverts results, not ready
// RL20: Inputs synchronised, intervals from prescaler
module sheet_detector
    import sheet_pkg::*;
#(
    parameter int MS_DIV = CYCLES_PER_MS,
    parameter int REACTION_MS = REACTION_MS_DEF,
    parameter int NUM_SENSORS = NUM_SENSORS_DEF
) (
    input wire logic clk,
    input wire logic srst,
    sheet_link_if.dev link,
    input wire logic cont_mode,
    input wire logic zero_adj_enable,
    input wire logic level_zero_volt,
    input wire logic sequencer_mode,
    input wire logic keypad_active,
    input wire logic fault_active,
    input wire logic system_test_active,
    input wire logic [1:0] sensor_type,
    input wire logic [3*NUM_SENSORS-1:0] sensor_results,
    output logic measuring,
    output logic zero_adjust_go
);
    // --------------------
    // Parameter checks
    // --------------------
    generate
        if (MS_DIV < 2 || REACTION_MS < 1 || REACTION_MS > 60000 || NUM_SENSORS < 1) begin : g_bad
            $error("sheet_detector: unsupported parameter value");
        end
    endgenerate

    localparam logic [15:0] REACT_MS = 16'(REACTION_MS);

    typedef enum logic [2:0] {
        S_IDLE,
        S_MEAS,
        S_PAUSE,
        S_ZACK,
        S_ZRUN
    } dstate_t;

    // --------------------
    // Helpers
    // --------------------
    // Two sheets anywhere wins; one sheet only if every sensor agrees
    function automatic logic [2:0] summarize(input logic [3*NUM_SENSORS-1:0] r);
        logic any_two;
        logic all_one;
        any_two = 1'b0;
        all_one = 1'b1;
        for (int i = 0; i < NUM_SENSORS; i++) begin
            any_two = any_two | r[3*i+RES_TWO];
            all_one = all_one & r[3*i+RES_ONE];
        end
        summarize = any_two ? 3'h4 : (all_one ? 3'h2 : 3'h1);
    endfunction

    // Extra pause per sensor family
    function automatic logic [15:0] pause_ms(input logic [1:0] t);
        case (t)
            2'h1: pause_ms = PAUSE_MID_MS;
            2'h2: pause_ms = PAUSE_LONG_MS;
            default: pause_ms = PAUSE_SHORT_MS;
        endcase
    endfunction

    // --------------------
    // Input synchronisers
    // --------------------
    logic [1:0] pin_in;
    logic [1:0] s1_q;
    logic [1:0] s2_q;
    logic [1:0] s3_q;
    logic [1:0] lvl_q;
    logic [1:0] lvl_d;
    logic [1:0] prev_q;

    assign pin_in = {link.zero_adjust_in, link.measure_start_in};

    // A change counts only once the last two stages agree
    generate
        for (genvar g = 0; g < 2; g++) begin : g_sync
            always_comb begin
                lvl_d[g] = (s2_q[g] == s3_q[g]) ? s3_q[g] : lvl_q[g];
            end
            always_ff @(posedge clk) begin
                if (srst) begin
                    s1_q[g] <= 1'b0;
                    s2_q[g] <= 1'b0;
                    s3_q[g] <= 1'b0;
                    lvl_q[g] <= 1'b0;
                    prev_q[g] <= 1'b0;
                end else begin
                    s1_q[g] <= pin_in[g];
                    s2_q[g] <= s1_q[g];
                    s3_q[g] <= s2_q[g];
                    lvl_q[g] <= lvl_d[g]; // RL20
                    prev_q[g] <= lvl_q[g];
                end
            end
        end
    endgenerate

    logic start_lvl;
    logic start_rise;
    logic zero_lvl;
    logic zero_rise;
    assign start_lvl = lvl_q[0];
    assign zero_lvl = lvl_q[1];
    assign start_rise = lvl_q[0] & ~prev_q[0];
    assign zero_rise = lvl_q[1] & ~prev_q[1];

    // --------------------
    // Millisecond prescaler
    // --------------------
    logic [31:0] div_q;
    logic [31:0] div_d;
    logic tick_q;
    logic tick_d;

    // One-cycle enable once per millisecond
    always_comb begin
        tick_d = (div_q == 32'(MS_DIV - 1)); // RL20
        div_d = tick_d ? 32'h0 : div_q + 32'h1;
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            div_q <= 32'h0;
            tick_q <= 1'b0;
        end else begin
            div_q <= div_d;
            tick_q <= tick_d;
        end
    end

    // --------------------
    // Sequencer
    // --------------------
    dstate_t state_q;
    dstate_t state_d;
    logic [15:0] ms_q;
    logic [15:0] ms_d;
    logic [2:0] res_q;
    logic [2:0] res_d;
    logic [2:0] last_q;
    logic [2:0] last_d;
    logic zgo_d;
    logic [2:0] outcome;

    // Single-sensor path uses sensor 0 only
    assign outcome = sequencer_mode ? summarize(sensor_results) // RL12
                                    : sensor_results[2:0];

    always_comb begin
        state_d = state_q;
        ms_d = (tick_q && ms_q != 16'hFFFF) ? ms_q + 16'h1 : ms_q;
        res_d = res_q;
        last_d = last_q;
        zgo_d = 1'b0;
        case (state_q)
            S_IDLE: begin
                ms_d = 16'h0;
                // Zero adjust stays deaf unless configured
                if (zero_rise && zero_adj_enable) begin // RL13
                    state_d = S_ZACK;
                    res_d = RES_ALL; // RL15
                end else if (start_rise) begin
                    state_d = S_MEAS;
                    res_d = RES_NONE; // RL5
                end
            end
            S_MEAS: begin
                if (cont_mode && !start_lvl) begin
                    state_d = S_IDLE;
                    res_d = last_q; // RL10
                end else if (ms_q >= REACT_MS) begin // RL7
                    res_d = outcome;
                    last_d = outcome;
                    ms_d = 16'h0;
                    // Single mode drops back to S_IDLE with the result frozen
                    state_d = cont_mode ? S_PAUSE : S_IDLE; // RL1
                end
            end
            S_PAUSE: begin
                if (!start_lvl) begin
                    state_d = S_IDLE; // RL10
                end else if (ms_q >= pause_ms(sensor_type)) begin // RL11
                    state_d = S_MEAS; // RL9
                    ms_d = 16'h0;
                end
            end
            S_ZACK: begin
                ms_d = 16'h0;
                if (!zero_lvl) begin
                    state_d = S_ZRUN;
                    zgo_d = 1'b1;
                end
            end
            S_ZRUN: begin
                // Real adjust work is outside; this bounds the busy time
                if (ms_q >= ZERO_ADJ_MS) begin // RL17
                    state_d = S_IDLE;
                    res_d = RES_NONE;
                end
            end
            default: begin
                state_d = S_IDLE;
                res_d = RES_NONE;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            state_q <= S_IDLE;
            ms_q <= 16'h0;
            res_q <= RES_NONE;
            last_q <= RES_NONE;
        end else begin
            state_q <= state_d;
            ms_q <= ms_d;
            res_q <= res_d;
            last_q <= last_d;
        end
    end

    // --------------------
    // Output registers
    // --------------------
    logic ready_q;
    logic [2:0] pins_q;
    logic meas_q;
    logic zgo_q;

    // Level inversion touches the result lines only
    always_ff @(posedge clk) begin
        if (srst) begin
            ready_q <= 1'b0;
            pins_q <= 3'h0;
            meas_q <= 1'b0;
            zgo_q <= 1'b0;
        end else begin
            ready_q <= ~(keypad_active | fault_active | system_test_active); // RL18
            pins_q <= res_d ^ {3{level_zero_volt}}; // RL19
            meas_q <= (state_d == S_MEAS);
            zgo_q <= zgo_d;
        end
    end

    assign link.ready_out = ready_q;
    assign link.sheet_result_outs = pins_q;
    assign measuring = meas_q;
    assign zero_adjust_go = zgo_q;
endmodule

// >>> sheet_link_properties.sv
// Timing checks on the handshake wires between controller and detector.
// Assumes one clock, sync active-high reset, placed beside the link.
`timescale 1ns/10ps
module sheet_link_properties #(
    parameter int MS_DIV = 4
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic measure_start_in,
    input wire logic zero_adjust_in,
    input wire logic ready_out,
    input wire logic [2:0] sheet_result_outs
);
    // One ms of slack, since both ends count on a coarse tick
    localparam int QUIET_CY = 29 * MS_DIV;
    localparam int ACK_CY = 31 * MS_DIV;
    localparam int ZERO_CY = 7001 * MS_DIV;
    int quiet_q, quiet_d, zhi_q, zhi_d, rel_q, rel_d;
    default clocking @(posedge clk); endclocking
    default disable iff (srst);
    // Idle span, zero-high span, time since release; first two saturate to avoid wrap
    always_comb begin
        quiet_d = (measure_start_in || zero_adjust_in) ? 0 : quiet_q + int'(quiet_q < ZERO_CY);
        zhi_d = zero_adjust_in ? zhi_q + int'(zhi_q < ZERO_CY) : 0;
        rel_d = (!zero_adjust_in && sheet_result_outs == 3'h7) ? rel_q + 1 : 0;
    end
    always_ff @(posedge clk) begin
        quiet_q <= srst ? 0 : quiet_d;
        zhi_q <= srst ? 0 : zhi_d;
        rel_q <= srst ? 0 : rel_d;
    end
    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    property p_quiet_start;
        $rose(measure_start_in) |-> quiet_q >= QUIET_CY;
    endproperty
    a_quiet_start: assert property (p_quiet_start) else $error("start too soon");
    property p_quiet_zero;
        $rose(zero_adjust_in) |-> quiet_q >= QUIET_CY;
    endproperty
    a_quiet_zero: assert property (p_quiet_zero) else $error("zero too soon");
    property p_ready_first;
        $rose(measure_start_in) || $rose(zero_adjust_in) |-> ready_out;
    endproperty
    a_ready_first: assert property (p_ready_first) else $error("raised while not ready");
    property p_start_ack;
        $rose(measure_start_in) |-> ##[1:ACK_CY] sheet_result_outs == 3'h0;
    endproperty
    a_start_ack: assert property (p_start_ack) else $error("no low ack");
    property p_hold;
        $onehot(sheet_result_outs) && quiet_q >= 8 |=> $stable(sheet_result_outs);
    endproperty
    a_hold: assert property (p_hold) else $error("result moved while idle");
    property p_zero_ack;
        $rose(sheet_result_outs == 3'h7) && zero_adjust_in |-> zhi_q <= ACK_CY;
    endproperty
    a_zero_ack: assert property (p_zero_ack) else $error("late high ack");
    property p_zero_drop;
        zero_adjust_in && sheet_result_outs == 3'h7 |-> ##[0:ACK_CY] !zero_adjust_in;
    endproperty
    a_zero_drop: assert property (p_zero_drop) else $error("zero held too long");
    property p_zero_done;
        !zero_adjust_in && sheet_result_outs == 3'h7 |-> rel_q <= ZERO_CY;
    endproperty
    a_zero_done: assert property (p_zero_done) else $error("zero adjust overran");
endmodule

// >>> sheet_measure_handshake_tb.sv
// Bench: APB orders to the controller, detector facing it over the link.
// Assumes MS_DIV shrunk to 4 so a 7 s zero adjust fits the run.
`timescale 1ns/10ps
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin error_cnt++; \
    $display("ERROR t=%0t got %h exp %h", $time, g, e); end end
module sheet_measure_handshake_tb
    import sheet_pkg::*;
();
    localparam int MS = 4;
    localparam logic [11:0] TS [4] = '{12'h492, 12'h254, 12'h492, 12'h491};
    localparam logic [2:0] TR [4] = '{3'h2, 3'h4, 3'h2, 3'h1};
    logic clk = 0, srst = 1, psel = 0, penable = 0, pwrite = 0, pready, pslverr, err;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic cont_mode = 0, zen = 0, lzv = 0, seq = 0;
    logic [2:0] nrdy = 3'h0;
    logic [1:0] sensor_type = 2'h1;
    logic [11:0] sens = 12'h000;
    int error_cnt = 0, checks = 0, n;
    sheet_link_if link ();
    sheet_detector #(.MS_DIV(MS), .REACTION_MS(3), .NUM_SENSORS(4)) i_sheet_detector (
        .clk(clk), .srst(srst), .link(link.dev), .cont_mode(cont_mode), .zero_adj_enable(zen),
        .level_zero_volt(lzv), .sequencer_mode(seq), .keypad_active(nrdy[0]),
        .fault_active(nrdy[1]), .system_test_active(nrdy[2]), .sensor_type(sensor_type),
        .sensor_results(sens), .measuring(), .zero_adjust_go());
    sheet_controller #(.MS_DIV(MS)) i_sheet_controller (.clk(clk), .srst(srst), .link(link.plc),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr));
    sheet_link_properties #(.MS_DIV(MS)) i_sheet_link_properties (.clk(clk), .srst(srst),
        .measure_start_in(link.measure_start_in), .zero_adjust_in(link.zero_adjust_in),
        .ready_out(link.ready_out), .sheet_result_outs(link.sheet_result_outs));
    // 200 MHz clock
    always #2.5 clk = ~clk;
    // One APB transfer; request held until pready is seen at an edge
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1; pwrite <= wr; paddr <= a; pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin @(posedge clk); n++; end while (pready !== 1'b1 && n < 50);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // Bounded wait for a result pattern on the wire
    task automatic wait_res(input logic [2:0] v, input int m);
        n = 0;
        while (link.sheet_result_outs !== v && n < m) begin @(posedge clk); n++; end
    endtask
    task automatic end_of_test();
        $display("checks %0d errors %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    // Watchdog, sized well past the longest path through the tests
    initial begin
        repeat (100000) @(posedge clk);
        error_cnt++;
        end_of_test();
    end
    // ------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------
    initial begin
        repeat (16) @(posedge clk);
        srst <= 1'b0;
        repeat (3) @(posedge clk);
        `CHK({link.ready_out, link.sheet_result_outs}, 4'h8)
        apb(0, REG_CFG, 0);
        `CHK(rd[2:0], CFG_RESET)
        apb(0, 8'h0C, 0);
        `CHK({err, rd}, {1'b1, 32'h0})
        for (int i = 0; i < 3; i++) begin
            nrdy <= 3'h1 << i;
            repeat (3) @(posedge clk);
            `CHK(link.ready_out, 1'b0)
        end
        // Order given while not ready must flag a fault, not start
        apb(1, REG_CMD, 32'h1);
        repeat (40 * MS) @(posedge clk);
        apb(0, REG_STATUS, 0);
        `CHK({rd[ST_FAULT], link.measure_start_in}, 2'b10)
        nrdy <= 3'h0;
        $display("test ready done");
        for (int i = 0; i < 4; i++) begin
            seq <= (i != 0);
            sens <= TS[i];
            apb(1, REG_CMD, 32'h1);
            wait_res(TR[i], 4000);
            `CHK(link.sheet_result_outs, TR[i])
            sens <= 12'h000;
            repeat (50 * MS) @(posedge clk);
            `CHK(link.sheet_result_outs, TR[i])
        end
        $display("test single done");
        seq <= 1'b0;
        cont_mode <= 1'b1;
        sens <= 12'h492;
        apb(1, REG_CFG, 32'h1);
        apb(1, REG_CMD, 32'h1);
        wait_res(3'h0, 8000);
        wait_res(3'h2, 8000);
        sens <= 12'h924;
        wait_res(3'h4, 1100 * MS);
        `CHK({n >= 995 * MS, link.measure_start_in}, 2'b11)
        sens <= 12'h492;
        apb(1, REG_CMD, 32'h4);
        repeat (1200 * MS) @(posedge clk);
        `CHK(link.sheet_result_outs, 3'h4)
        cont_mode <= 1'b0;
        apb(1, REG_CFG, 32'h0);
        $display("test continuous done");
        zen <= 1'b1;
        apb(1, REG_CMD, 32'h2);
        wait_res(RES_ALL, 20000);
        `CHK(link.sheet_result_outs, RES_ALL)
        wait_res(RES_NONE, 7100 * MS);
        `CHK(link.sheet_result_outs, RES_NONE)
        zen <= 1'b0;
        apb(1, REG_CMD, 32'h2);
        n = 0;
        repeat (300 * MS) begin @(posedge clk); n += (link.sheet_result_outs !== RES_NONE); end
        `CHK(n, 0)
        $display("test zero done");
        lzv <= 1'b1;
        repeat (3) @(posedge clk);
        `CHK({link.ready_out, link.sheet_result_outs}, 4'hF)
        lzv <= 1'b0;
        $display("test level done");
        end_of_test();
    end
endmodule
